/* File: src/timer2_control_flags.sv */
// timer 2: 16-bit count, capture/reload pair, control and mode registers
// assumes a synchronous sfr bus: one-cycle wr/rd strobes, read data next cycle
`timescale 1ns/1ps
module timer2_control_flags
	import timer2_pkg::*;
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_srst,
	// sfr bus
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// pins
	input  wire logic       i_count_input_pin,
	input  wire logic       i_trigger_pin,
	// interrupt and serial port
	input  wire logic       i_irq_enable,
	input  wire logic       i_timer1_overflow,
	output logic            o_irq,
	output logic            o_rx_baud_tick,
	output logic            o_tx_baud_tick
);
	// ************************************************************
	// state
	// ************************************************************
	sfr_req_t  req;
	control_t  ctrl_q;
	control_t  wctrl;
	logic      up_down_enable_q;
	logic [7:0] capture_reload_low_q;
	logic [7:0] capture_reload_high_q;
	logic [15:0] count_q;
	logic      mc_tick;
	logic      count_fall;
	logic      trig_fall;
	logic      baud;
	logic      step;
	logic      overflow;
	logic      trig_event;
	logic      ovf_q;
	op_mode_t  mode;

	assign req   = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
	assign wctrl = control_t'(req.wdata);

	// ************************************************************
	// machine cycle and pin sampling
	// ************************************************************
	machine_cycle_gen #(
		.DIVIDE(OSC_PER_MACHINE)
	) u_mc (
		.i_clk  (i_clk),
		.i_srst (i_srst),
		.o_tick (mc_tick)
	);

	pin_fall_sampler u_count_pin (
		.i_clk    (i_clk),
		.i_srst   (i_srst),
		.i_pin    (i_count_input_pin),
		.i_sample (mc_tick),
		.o_fall   (count_fall)
	);

	pin_fall_sampler u_trig_pin (
		.i_clk    (i_clk),
		.i_srst   (i_srst),
		.i_pin    (i_trigger_pin),
		.i_sample (mc_tick),
		.o_fall   (trig_fall)
	);

	// ************************************************************
	// mode decode
	// ************************************************************
	assign baud = ctrl_q.receive_baud_select | ctrl_q.transmit_baud_select;

	always_comb begin
		if (!ctrl_q.run_control) begin
			mode = MODE_OFF; // R16
		end else if (baud) begin
			mode = MODE_BAUD; // R16
		end else if (ctrl_q.capture_reload_select) begin
			mode = MODE_CAPTURE; // R16
		end else begin
			mode = MODE_RELOAD; // R16
		end
	end

	// timer source or pin edge, gated by run
	assign step = ctrl_q.run_control // R8
		& (ctrl_q.counter_timer_select ? count_fall : mc_tick); // R9 R17 R18
	assign overflow   = step & (count_q == COUNT_ALL_ONES); // R19
	// trigger pin is dead while the timer makes baud clocks
	assign trig_event = trig_fall & ctrl_q.trigger_pin_enable & ~baud; // R7

	// ************************************************************
	// count register
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			count_q <= COUNT_RESET;
		end else if (overflow && mode != MODE_CAPTURE) begin
			count_q <= {capture_reload_high_q, capture_reload_low_q}; // R11 R12
		end else if (trig_event && !ctrl_q.capture_reload_select) begin
			count_q <= {capture_reload_high_q, capture_reload_low_q}; // R11
		end else if (step) begin
			count_q <= count_q + 16'h0001;
		end else if (req.wr && req.addr == ADDR_COUNT_LOW) begin
			count_q[7:0] <= req.wdata;
		end else if (req.wr && req.addr == ADDR_COUNT_HIGH) begin
			count_q[15:8] <= req.wdata;
		end
	end

	// ************************************************************
	// capture / reload pair
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			capture_reload_low_q  <= 8'h00;
			capture_reload_high_q <= 8'h00;
		end else if (trig_event && ctrl_q.capture_reload_select) begin
			capture_reload_low_q  <= count_q[7:0]; // R10 R13
			capture_reload_high_q <= count_q[15:8]; // R10 R13
		end else if (req.wr && req.addr == ADDR_CAP_LOW) begin
			capture_reload_low_q <= req.wdata; // R13
		end else if (req.wr && req.addr == ADDR_CAP_HIGH) begin
			capture_reload_high_q <= req.wdata; // R13
		end
	end

	// ************************************************************
	// control and mode registers
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrl_q <= control_t'(CONTROL_RESET); // R14
		end else begin
			if (req.wr && req.addr == ADDR_CONTROL) begin
				ctrl_q <= wctrl; // R14
			end
			// hardware set wins over a software clear in the same cycle
			if (overflow && !baud) begin
				ctrl_q.overflow_flag <= 1'b1; // R1 R2
			end
			if (trig_event) begin
				ctrl_q.external_event_flag <= 1'b1; // R3
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			up_down_enable_q <= 1'b0;
		end else if (req.wr && req.addr == ADDR_MODE) begin
			up_down_enable_q <= req.wdata[MODE_UPDOWN_BIT];
		end
	end

	// ************************************************************
	// interrupt and baud clock outputs
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= i_irq_enable & (ctrl_q.overflow_flag // R1
				| (ctrl_q.external_event_flag & ~up_down_enable_q)); // R4
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ovf_q          <= 1'b0;
			o_rx_baud_tick <= 1'b0;
			o_tx_baud_tick <= 1'b0;
		end else begin
			ovf_q          <= overflow; // R19
			o_rx_baud_tick <= ctrl_q.receive_baud_select ? overflow : i_timer1_overflow; // R5
			o_tx_baud_tick <= ctrl_q.transmit_baud_select ? overflow : i_timer1_overflow; // R6
		end
	end

	// ************************************************************
	// read port
	// ************************************************************
	// unlisted addresses read zero; writes to them are dropped
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rdata <= 8'h00;
		end else if (req.rd) begin
			unique case (req.addr)
				ADDR_CONTROL:    o_rdata <= ctrl_q;
				ADDR_MODE:       o_rdata <= {7'h00, up_down_enable_q};
				ADDR_CAP_LOW:    o_rdata <= capture_reload_low_q;
				ADDR_CAP_HIGH:   o_rdata <= capture_reload_high_q;
				ADDR_COUNT_LOW:  o_rdata <= count_q[7:0];
				ADDR_COUNT_HIGH: o_rdata <= count_q[15:8];
				default:         o_rdata <= UNMAPPED_READ; // R15
			endcase
		end
	end
endmodule

/* File: src/timer2_pkg.sv */
// constants, field layouts and carrier types of the timer 2 control block
// assumes an 8-bit special function register bus clocked by the oscillator
//
// Overview of operation
// (R1) overflow sets bit 7 flag; software clears
// (R2) no overflow flag while either baud select set
// (R3) enabled trigger falling edge sets bit 6 flag
// (R4) external flag interrupts unless up/down mode
// (R5) bit 5 picks receive baud clock source
// (R6) bit 4 picks transmit baud clock source
// (R7) bit 3 enables trigger pin unless baud
// (R8) bit 2 runs or stops the counter
// (R9) bit 1 picks timer or pin counting
// (R10) capture mode copies count on trigger edge
// (R11) reload mode reloads on overflow and trigger
// (R12) baud selects force reload on every overflow
// (R13) high/low capture reload byte pair exists
// (R14) control register at 0c8h, resets zero
// (R15) software never writes unlisted addresses
// (R16) run, baud, capture, reload mode decode
// (R17) timer mode counts once per machine cycle
// (R18) pin counted on high then low sample
// (R19) ffff to 0000 gives one overflow pulse
package timer2_pkg;

	// ************************************************************
	// register addresses
	// ************************************************************
	localparam logic [7:0] ADDR_CONTROL    = 8'hc8;
	localparam logic [7:0] ADDR_MODE       = 8'hc9;
	localparam logic [7:0] ADDR_CAP_LOW    = 8'hca;
	localparam logic [7:0] ADDR_CAP_HIGH   = 8'hcb;
	localparam logic [7:0] ADDR_COUNT_LOW  = 8'hcc;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;

	// ************************************************************
	// reset values and timing
	// ************************************************************
	localparam logic [7:0]  CONTROL_RESET      = 8'h00;
	localparam logic [15:0] COUNT_RESET        = 16'h0000;
	localparam logic [15:0] COUNT_ALL_ONES     = 16'hffff;
	localparam logic [7:0]  UNMAPPED_READ      = 8'h00;
	localparam int          OSC_PER_MACHINE    = 12;
	localparam int          MODE_UPDOWN_BIT    = 0;

	// ************************************************************
	// carrier types
	// ************************************************************
	typedef struct packed {
		logic overflow_flag;
		logic external_event_flag;
		logic receive_baud_select;
		logic transmit_baud_select;
		logic trigger_pin_enable;
		logic run_control;
		logic counter_timer_select;
		logic capture_reload_select;
	} control_t;

	typedef enum {MODE_OFF, MODE_RELOAD, MODE_CAPTURE, MODE_BAUD} op_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sfr_req_t;

endpackage

/* File: src/machine_cycle_gen.sv */
// machine cycle strobe from the oscillator clock
// assumes i_clk is the oscillator itself
`timescale 1ns/1ps
module machine_cycle_gen
	import timer2_pkg::*;
#(
	parameter int DIVIDE = OSC_PER_MACHINE
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_srst,
	// strobe
	output logic      o_tick
);
	// a divide below two leaves no room for the strobe to drop
	if (DIVIDE < 2) begin : g_bad_divide
		$error("DIVIDE must be at least 2");
	end

	logic [$clog2(DIVIDE)-1:0] cnt_q;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_q  <= '0;
			o_tick <= 1'b0;
		end else begin
			o_tick <= (cnt_q == ($clog2(DIVIDE))'(DIVIDE - 1)); // R17
			if (cnt_q == ($clog2(DIVIDE))'(DIVIDE - 1)) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule

/* File: src/pin_fall_sampler.sv */
// samples an asynchronous pin once per machine cycle, flags a high-then-low pair
// assumes i_sample is a one-cycle strobe on i_clk
`timescale 1ns/1ps
module pin_fall_sampler (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_srst,
	// pin and strobe
	input  wire logic i_pin,
	input  wire logic i_sample,
	// result
	output logic      o_fall
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// two flops before anything looks at the pin
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end else begin
			meta_q <= i_pin;
			sync_q <= meta_q;
		end
	end

	// two samples needed, so at most one count per two machine cycles
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			prev_q <= 1'b1;
			o_fall <= 1'b0;
		end else begin
			o_fall <= i_sample & prev_q & ~sync_q; // R18
			if (i_sample) begin
				prev_q <= sync_q;
			end
		end
	end
endmodule

/* File: test/timer2_control_flags_properties.sv */
// port checks for the timer 2 block
// assumes only software writes control bits 5..0
`timescale 1ns/1ps
module timer2_control_flags_properties
	import timer2_pkg::*;
(
	input wire logic       i_clk,
	input wire logic       i_srst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       i_irq_enable,
	input wire logic       i_timer1_overflow,
	input wire logic       o_irq,
	input wire logic       o_rx_baud_tick,
	input wire logic       o_tx_baud_tick
);
	// software copy of bits 5..0; flags are left out since hardware sets them
	logic [5:0] sw_q;
	always_ff @(posedge i_clk) begin
		if (i_srst)
			sw_q <= 6'h00;
		else if (i_wr && i_addr == ADDR_CONTROL)
			sw_q <= i_wdata[5:0];
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	chk_reset_quiet: assert property ($fell(i_srst) |-> !o_irq && !o_rx_baud_tick && !o_tx_baud_tick)
		else $error("outputs busy after reset");
	chk_irq_gated: assert property (!i_irq_enable |=> !o_irq)
		else $error("irq without enable");
	chk_rx_timer1: assert property (!sw_q[5] |=> o_rx_baud_tick == $past(i_timer1_overflow))
		else $error("rx tick source wrong");
	chk_tx_timer1: assert property (!sw_q[4] |=> o_tx_baud_tick == $past(i_timer1_overflow))
		else $error("tx tick source wrong");
	chk_tx_single: assert property (sw_q[4] && $past(sw_q[4]) && o_tx_baud_tick |=> !o_tx_baud_tick)
		else $error("overflow pulse too long");
	chk_unmapped_zero: assert property (i_rd && !(i_addr inside {[8'hc8:8'hcd]}) |=> o_rdata == UNMAPPED_READ)
		else $error("unmapped read not zero");
	chk_rdata_stands: assert property (!i_rd |=> $stable(o_rdata))
		else $error("read data moved");
	chk_ctrl_readback: assert property (i_rd && i_addr == ADDR_CONTROL |=> o_rdata[5:0] == $past(sw_q))
		else $error("control readback wrong");
endmodule
bind timer2_control_flags timer2_control_flags_properties u_props (.i_clk, .i_srst, .i_addr, .i_wdata,
	.i_wr, .i_rd, .o_rdata, .i_irq_enable, .i_timer1_overflow, .o_irq, .o_rx_baud_tick, .o_tx_baud_tick);

/* File: test/timer2_pin_partner.sv */
// count and trigger pins as the board drives them
// assumes the oscillator clock of the bench
`timescale 1ns/1ps
module timer2_pin_partner (
	input  wire logic i_clk,
	output logic      o_count_pin,
	output logic      o_trig_pin
);
	initial begin
		o_count_pin = 1'b1;
		o_trig_pin = 1'b1;
	end
	// each level held two machine cycles so a sample always sees it
	task automatic fall(input bit trig);
		repeat (24) @(posedge i_clk);
		#1;
		o_trig_pin = !trig;
		o_count_pin = trig;
		repeat (24) @(posedge i_clk);
		#1;
		o_trig_pin = 1'b1;
		o_count_pin = 1'b1;
	endtask
endmodule

/* File: test/tb_timer2_control_flags.sv */
// self-checking bench for the timer 2 block
// assumes a 20 MHz clock and the pin partner beside the design
`timescale 1ns/1ps
module tb_timer2_control_flags;
	import timer2_pkg::*;
	logic       clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, t1 = 1'b0, irq_en = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got;
	logic       cnt_pin, trig_pin, irq, rx_tick, tx_tick;
	int         n_mismatch = 0, compares = 0, ticks, n;
	logic [7:0] cfg[4] = '{8'h0d, 8'h0c, 8'h04, 8'h1c};
	logic [7:0] ra[4] = '{ADDR_CAP_HIGH, ADDR_COUNT_HIGH, ADDR_COUNT_HIGH, ADDR_COUNT_HIGH};
	logic [7:0] ex[4] = '{8'hab, 8'h34, 8'hab, 8'hab};
	always #25 clk = ~clk;
	always @(posedge clk) t1 <= #1 ($urandom_range(7) == 0);
	always @(posedge clk) ticks += tx_tick;
	timer2_control_flags u_dut (.i_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_count_input_pin(cnt_pin), .i_trigger_pin(trig_pin),
		.i_irq_enable(irq_en), .i_timer1_overflow(t1), .o_irq(irq), .o_rx_baud_tick(rx_tick),
		.o_tx_baud_tick(tx_tick));
	timer2_pin_partner pins (.i_clk(clk), .o_count_pin(cnt_pin), .o_trig_pin(trig_pin));
	// flags read back as zero after a software write that clears bits 7 and 6
	function automatic logic [7:0] rb(input logic [7:0] w);
		return {2'b00, w[5:0]};
	endfunction
	task automatic chk(input logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, d);
		@(posedge clk);
		#1;
		{wr, rd, addr, wdata} = {w, ~w, a, d};
		@(posedge clk);
		#1;
		{wr, rd} = 2'b00;
		got = rdata;
	endtask
	task automatic load(input logic [15:0] c, r);
		acc(1, ADDR_COUNT_LOW, c[7:0]);
		acc(1, ADDR_COUNT_HIGH, c[15:8]);
		acc(1, ADDR_CAP_LOW, r[7:0]);
		acc(1, ADDR_CAP_HIGH, r[15:8]);
	endtask
	task automatic wrap_up;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#(40000 * 50);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		void'($urandom(58809));
		repeat (4) @(posedge clk);
		#1;
		srst = 1'b0;
		for (int a = 0; a < 6; a++) begin
			acc(0, 8'(ADDR_CONTROL + a), 0);
			chk(got, CONTROL_RESET);
		end
		acc(0, 8'($urandom_range(8'hc7)), 0);
		chk(got, UNMAPPED_READ);
		repeat (4) begin
			n = $urandom;
			acc(1, ADDR_CONTROL, 8'(n) & 8'h3f);
			acc(0, ADDR_CONTROL, 0);
			chk(got, rb(8'(n)));
		end
		acc(1, ADDR_CONTROL, 8'h00);
		load(16'hfff0, 16'h1200 | 16'($urandom_range(127)));
		irq_en = 1'b1;
		acc(1, ADDR_CONTROL, 8'h04);
		repeat (300) @(posedge clk);
		acc(0, ADDR_CONTROL, 0);
		chk(got, 8'h84);
		acc(0, ADDR_COUNT_HIGH, 0);
		chk(got, 8'h12);
		chk({7'h0, irq}, 8'h01);
		acc(1, ADDR_CONTROL, 8'h00);
		acc(0, ADDR_COUNT_LOW, 0);
		n = got;
		repeat (30) @(posedge clk);
		acc(0, ADDR_COUNT_LOW, 0);
		chk(got, 8'(n));
		chk({7'h0, irq}, 8'h00);
		load(16'hfff0, 16'hfffc);
		acc(1, ADDR_CONTROL, 8'h15);
		ticks = 0;
		repeat (480) @(posedge clk);
		n = ticks;
		acc(0, ADDR_CONTROL, 0);
		chk(got, 8'h15);
		acc(1, ADDR_CONTROL, 8'h00);
		chk(8'(n inside {[5:7]}), 8'h01);
		acc(0, ADDR_COUNT_HIGH, 0);
		chk(got, 8'hff);
		foreach (cfg[i]) begin
			load(16'hab00, 16'h3400);
			acc(1, ADDR_CONTROL, cfg[i]);
			pins.fall(1'b1);
			acc(0, ADDR_CONTROL, 0);
			chk(got, cfg[i] | {1'b0, i < 2, 6'h00});
			chk({7'h0, irq}, {7'h0, i < 2});
			acc(1, ADDR_CONTROL, 8'h00);
			acc(0, ra[i], 0);
			chk(got, ex[i]);
		end
		acc(1, ADDR_MODE, 8'h01);
		acc(1, ADDR_CONTROL, 8'h08);
		pins.fall(1'b1);
		acc(0, ADDR_CONTROL, 0);
		chk(got, 8'h48);
		chk({7'h0, irq}, 8'h00);
		acc(1, ADDR_CONTROL, 8'h00);
		acc(1, ADDR_MODE, 8'h00);
		load(16'h0000, 16'h0000);
		n = $urandom_range(5, 1);
		acc(1, ADDR_CONTROL, 8'h06);
		repeat (n) pins.fall(1'b0);
		acc(1, ADDR_CONTROL, 8'h00);
		acc(0, ADDR_COUNT_LOW, 0);
		chk(got, 8'(n));
		wrap_up();
	end
endmodule
